//--- rtl/wocfg_pkg.sv
// Package: register map, field positions and timing counts of the option bank
package wocfg_pkg;

    // ------------------------------------------------------------------
    // Register indices and byte addresses
    // ------------------------------------------------------------------
    localparam logic [7:0]  REG_TWO_INDEX  = 8'h1e;
    localparam logic [7:0]  REG_ONE_INDEX  = 8'h1f;
    localparam logic [11:0] REG_TWO_ADDR   = {2'h0, REG_TWO_INDEX, 2'h0};
    localparam logic [11:0] REG_ONE_ADDR   = {2'h0, REG_ONE_INDEX, 2'h0};
    localparam logic [11:0] EVENT_ADDR     = 12'h100;
    localparam logic [11:0] STATUS_ADDR    = 12'h104;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0]  OPT_RESET      = 8'h00;

    // ------------------------------------------------------------------
    // Option register two fields
    // ------------------------------------------------------------------
    localparam int CRYSTAL_EN_BIT  = 0;
    localparam int SLOW_XTAL_BIT   = 1;
    localparam int EXT_CLK_EN_BIT  = 2;
    localparam int OSC_STOP_EN_BIT = 3;

    // ------------------------------------------------------------------
    // Option register one fields
    // ------------------------------------------------------------------
    localparam int WDOG_DIS_BIT    = 0;
    localparam int STOP_EN_BIT     = 1;
    localparam int SHORT_REC_BIT   = 2;
    localparam int VOLT_MODE_BIT   = 3;
    localparam int DET_PWR_DIS_BIT = 4;
    localparam int DET_RST_DIS_BIT = 5;
    localparam int DET_STOP_EN_BIT = 6;
    localparam int WDOG_RATE_BIT   = 7;

    // ------------------------------------------------------------------
    // Event register bits (write one to pulse)
    // ------------------------------------------------------------------
    localparam int EV_WDOG_CLR_BIT = 0;

    // ------------------------------------------------------------------
    // Cycle counts and slow crystal frequency
    // ------------------------------------------------------------------
    localparam int STAB_LONG       = 4096;
    localparam int STAB_SHORT      = 16;
    localparam int REC_LONG        = 4096;
    localparam int REC_SHORT       = 32;
    localparam int WDOG_LONG       = 262128;
    localparam int WDOG_SHORT      = 8176;
    localparam int SLOW_XTAL_HZ_X10 = 3072000;

endpackage : wocfg_pkg

//--- rtl/wocfg_option_bank.sv
// Write-once option registers with APB slave and option decoding
//Contract
//- Each option register accepts one write per reset
//- Reset clears every option bit except voltage mode
//- Two consecutive registers, readable at any time
//- Voltage-mode bit writable once per power-on
//- Voltage-mode bit cleared only by power-on reset
//- External clock and crystal enables choose pin use
//- Crystal enable picks 4096 or 16 stabilization cycles
//- Crystal enable picks monitor frequency range
//- Slow crystal select needs external clock enable
//- Oscillator-in-stop keeps clocks running in stop
//- Rate select picks 8176 or 262128 watchdog cycles
//- Detector runs in stop: stop enable, powered
//- Reset disable suppresses detector reset requests
//- Power disable powers down the detector
//- Voltage mode selects 5-V or 3-V trip
//- Short recovery: 32 cycles, else 4096
//- Detector reset exit always uses long recovery
//- Stop disabled makes stop an illegal opcode
//- Watchdog disable stops the watchdog
//- Watchdog counter resets on overflow unless cleared
`timescale 1ns/10ps
module wocfg_option_bank #(
    parameter int WDOG_W = 18,
    parameter int REC_W  = 13
) (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        porRstn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        stopExecReq,
    input  wire logic        detectorTripIn,
    input  wire logic        stopWakeIn,
    output logic             oscInputIsClock,
    output logic             oscOutputIsCrystal,
    output logic             slowCrystalMode,
    output logic [12:0]      stabCycles,
    output logic             monitorXtalRange,
    output logic             monitorExpectLow,
    output logic             genClocksInStop,
    output logic             detectorPowerOn,
    output logic             detectorActiveInStop,
    output logic             detectorResetReq,
    output logic             detectorFiveVolt,
    output logic             stopEntered,
    output logic             illegalOpcode,
    output logic             stopInProgress,
    output logic             watchdogEnabled,
    output logic             watchdogResetReq
);

    // ------------------------------------------------------------------
    // Pin synchronisers (external async inputs)
    // ------------------------------------------------------------------
    logic [1:0] tripSync_q, tripSync_d;
    logic [1:0] wakeSync_q, wakeSync_d;

    always_comb begin
        tripSync_d = {tripSync_q[0], detectorTripIn};
        wakeSync_d = {wakeSync_q[0], stopWakeIn};
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tripSync_q <= 2'h0;
            wakeSync_q <= 2'h0;
        end else begin
            tripSync_q <= tripSync_d;
            wakeSync_q <= wakeSync_d;
        end
    end

    // ------------------------------------------------------------------
    // Option storage
    // ------------------------------------------------------------------
    logic [7:0] optTwo_q, optTwo_d;
    logic [7:0] optOne_q, optOne_d;
    logic       twoDone_q, twoDone_d;
    logic       oneDone_q, oneDone_d;
    logic       voltMode_q, voltMode_d;
    logic       voltDone_q, voltDone_d;
    logic       access;
    logic       wrTwo, wrOne, wrEvent;

    assign access  = psel & penable;
    assign wrTwo   = access & pwrite & pstrb[0] & (paddr == wocfg_pkg::REG_TWO_ADDR);
    assign wrOne   = access & pwrite & pstrb[0] & (paddr == wocfg_pkg::REG_ONE_ADDR);
    assign wrEvent = access & pwrite & pstrb[0] & (paddr == wocfg_pkg::EVENT_ADDR);

    always_comb begin
        optTwo_d  = optTwo_q;
        optOne_d  = optOne_q;
        twoDone_d = twoDone_q;
        oneDone_d = oneDone_q;
        if (wrTwo && !twoDone_q) begin
            optTwo_d  = {4'h0, pwdata[3:0]};
            twoDone_d = 1'b1;
        end
        if (wrOne && !oneDone_q) begin
            optOne_d  = pwdata[7:0];
            oneDone_d = 1'b1;
        end
        // Later writes fall through untouched
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            optTwo_q  <= wocfg_pkg::OPT_RESET;
            optOne_q  <= wocfg_pkg::OPT_RESET;
            twoDone_q <= 1'b0;
            oneDone_q <= 1'b0;
        end else begin
            optTwo_q  <= optTwo_d;
            optOne_q  <= optOne_d;
            twoDone_q <= twoDone_d;
            oneDone_q <= oneDone_d;
        end
    end

    // Voltage mode lives in the power-on domain only
    always_comb begin
        voltMode_d = voltMode_q;
        voltDone_d = voltDone_q;
        if (wrOne && !voltDone_q) begin
            voltMode_d = pwdata[wocfg_pkg::VOLT_MODE_BIT];
            voltDone_d = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge porRstn) begin
        if (!porRstn) begin
            voltMode_q <= 1'b0;
            voltDone_q <= 1'b0;
        end else begin
            voltMode_q <= voltMode_d;
            voltDone_q <= voltDone_d;
        end
    end

    // ------------------------------------------------------------------
    // APB read path and response
    // ------------------------------------------------------------------
    logic [31:0] prdata_d;
    logic        pready_d, pslverr_d;
    logic [7:0]  oneView;

    always_comb begin
        oneView = optOne_q;
        oneView[wocfg_pkg::VOLT_MODE_BIT] = voltMode_q;
        prdata_d  = 32'h0;
        pslverr_d = 1'b0;
        pready_d  = psel & ~penable;
        if (psel && !penable) begin
            case (paddr)
                wocfg_pkg::REG_TWO_ADDR: prdata_d = {24'h0, optTwo_q};
                wocfg_pkg::REG_ONE_ADDR: prdata_d = {24'h0, oneView};
                wocfg_pkg::EVENT_ADDR:   prdata_d = 32'h0;
                wocfg_pkg::STATUS_ADDR:  prdata_d = {28'h0, stopInProgress,
                                                     voltDone_q, oneDone_q, twoDone_q};
                default:                 pslverr_d = 1'b1;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            prdata  <= 32'h0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            prdata  <= prdata_d;
            pready  <= pready_d;
            pslverr <= pslverr_d;
        end
    end

    // ------------------------------------------------------------------
    // Static option decode
    // ------------------------------------------------------------------
    logic extClk, xtal;
    assign extClk = optTwo_q[wocfg_pkg::EXT_CLK_EN_BIT];
    assign xtal   = optTwo_q[wocfg_pkg::CRYSTAL_EN_BIT];

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            oscInputIsClock      <= 1'b0;
            oscOutputIsCrystal   <= 1'b0;
            slowCrystalMode      <= 1'b0;
            stabCycles           <= 13'(wocfg_pkg::STAB_SHORT);
            monitorXtalRange     <= 1'b0;
            monitorExpectLow     <= 1'b0;
            genClocksInStop      <= 1'b0;
            detectorPowerOn      <= 1'b1;
            detectorActiveInStop <= 1'b0;
            detectorFiveVolt     <= 1'b0;
            watchdogEnabled      <= 1'b1;
        end else begin
            oscInputIsClock      <= extClk;
            oscOutputIsCrystal   <= extClk & xtal;
            slowCrystalMode      <= extClk & optTwo_q[wocfg_pkg::SLOW_XTAL_BIT];
            monitorExpectLow     <= extClk & optTwo_q[wocfg_pkg::SLOW_XTAL_BIT];
            stabCycles           <= xtal ? 13'(wocfg_pkg::STAB_LONG)
                                         : 13'(wocfg_pkg::STAB_SHORT);
            monitorXtalRange     <= xtal;
            genClocksInStop      <= optTwo_q[wocfg_pkg::OSC_STOP_EN_BIT];
            detectorPowerOn      <= ~optOne_q[wocfg_pkg::DET_PWR_DIS_BIT];
            detectorActiveInStop <= optOne_q[wocfg_pkg::DET_STOP_EN_BIT]
                                    & ~optOne_q[wocfg_pkg::DET_PWR_DIS_BIT];
            detectorFiveVolt     <= voltMode_q;
            watchdogEnabled      <= ~optOne_q[wocfg_pkg::WDOG_DIS_BIT];
        end
    end

    // ------------------------------------------------------------------
    // Detector reset, stop handling and recovery
    // ------------------------------------------------------------------
    logic             trip;
    logic             detRst_d, illegal_d, entered_d;
    logic             inStop_q, inStop_d;
    logic             recov_q, recov_d;
    logic [REC_W-1:0] recCnt_q, recCnt_d;

    assign trip = tripSync_q[1] & ~optOne_q[wocfg_pkg::DET_PWR_DIS_BIT]
                  & (~inStop_q | optOne_q[wocfg_pkg::DET_STOP_EN_BIT]);

    always_comb begin
        detRst_d  = trip & ~optOne_q[wocfg_pkg::DET_RST_DIS_BIT];
        illegal_d = stopExecReq & ~optOne_q[wocfg_pkg::STOP_EN_BIT];
        entered_d = 1'b0;
        inStop_d  = inStop_q;
        recov_d   = recov_q;
        recCnt_d  = recCnt_q;
        if (!inStop_q && !recov_q && stopExecReq && optOne_q[wocfg_pkg::STOP_EN_BIT]) begin
            inStop_d  = 1'b1;
            entered_d = 1'b1;
        end else if (inStop_q && (wakeSync_q[1] || detRst_d)) begin
            inStop_d = 1'b0;
            recov_d  = 1'b1;
            // Detector reset exit never takes the short path
            if (optOne_q[wocfg_pkg::SHORT_REC_BIT] && !detRst_d) begin
                recCnt_d = REC_W'(wocfg_pkg::REC_SHORT - 1);
            end else begin
                recCnt_d = REC_W'(wocfg_pkg::REC_LONG - 1);
            end
        end else if (recov_q) begin
            if (recCnt_q == '0) begin
                recov_d = 1'b0;
            end else begin
                recCnt_d = recCnt_q - 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            detectorResetReq <= 1'b0;
            illegalOpcode    <= 1'b0;
            stopEntered      <= 1'b0;
            inStop_q         <= 1'b0;
            recov_q          <= 1'b0;
            recCnt_q         <= '0;
            stopInProgress   <= 1'b0;
        end else begin
            detectorResetReq <= detRst_d;
            illegalOpcode    <= illegal_d;
            stopEntered      <= entered_d;
            inStop_q         <= inStop_d;
            recov_q          <= recov_d;
            recCnt_q         <= recCnt_d;
            stopInProgress   <= inStop_d | recov_d;
        end
    end

    // ------------------------------------------------------------------
    // Watchdog counter; clock is the block clock, stalled in stop
    // ------------------------------------------------------------------
    logic [WDOG_W-1:0] wdCnt_q, wdCnt_d;
    logic              wdRst_d;
    logic [WDOG_W-1:0] wdLimit;

    always_comb begin
        wdLimit = optOne_q[wocfg_pkg::WDOG_RATE_BIT]
                  ? WDOG_W'(wocfg_pkg::WDOG_SHORT - 1)
                  : WDOG_W'(wocfg_pkg::WDOG_LONG - 1);
        wdCnt_d = wdCnt_q;
        wdRst_d = 1'b0;
        if (optOne_q[wocfg_pkg::WDOG_DIS_BIT]
            || (wrEvent && pwdata[wocfg_pkg::EV_WDOG_CLR_BIT])
            || stopEntered) begin
            wdCnt_d = '0;
        end else if (!inStop_q) begin
            if (wdCnt_q >= wdLimit) begin
                wdRst_d = 1'b1;
                wdCnt_d = '0;
            end else begin
                wdCnt_d = wdCnt_q + 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wdCnt_q          <= '0;
            watchdogResetReq <= 1'b0;
        end else begin
            wdCnt_q          <= wdCnt_d;
            watchdogResetReq <= wdRst_d;
        end
    end

endmodule : wocfg_option_bank

//--- test/wocfg_option_bank_assertions.sv
// Checker: port-level properties of the write-once option bank
`timescale 1ns/10ps
module wocfg_option_bank_assertions #(
    parameter int WDOG_W = 18,
    parameter int REC_W  = 13
) (
    input wire logic        clk,
    input wire logic        rstn,
    input wire logic        porRstn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        stopExecReq,
    input wire logic        detectorTripIn,
    input wire logic        stopWakeIn,
    input wire logic        oscInputIsClock,
    input wire logic        oscOutputIsCrystal,
    input wire logic        slowCrystalMode,
    input wire logic [12:0] stabCycles,
    input wire logic        monitorXtalRange,
    input wire logic        monitorExpectLow,
    input wire logic        genClocksInStop,
    input wire logic        detectorPowerOn,
    input wire logic        detectorActiveInStop,
    input wire logic        detectorResetReq,
    input wire logic        detectorFiveVolt,
    input wire logic        stopEntered,
    input wire logic        illegalOpcode,
    input wire logic        stopInProgress,
    input wire logic        watchdogEnabled,
    input wire logic        watchdogResetReq
);
    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    chk_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    chk_ready_one_cycle: assert property (pready |=> !pready)
        else $error("ready held too long");
    chk_err_zero_data: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("bad error response");
    chk_upper_bits_zero: assert property (pready |-> prdata[31:8] == 24'h0)
        else $error("upper read bits set");
    chk_crystal_pin_use: assert property (oscOutputIsCrystal |-> oscInputIsClock)
        else $error("crystal pin without clock pin");
    chk_stab_count: assert property (
        stabCycles == (monitorXtalRange ? 13'h1000 : 13'h0010))
        else $error("stabilization count mismatch");
    chk_slow_needs_ext: assert property (
        (slowCrystalMode || monitorExpectLow) |-> oscInputIsClock)
        else $error("slow crystal without external clock");
    chk_det_stop_power: assert property (detectorActiveInStop |-> detectorPowerOn)
        else $error("detector in stop while powered down");
    chk_det_off_quiet: assert property (!detectorPowerOn |-> !detectorResetReq)
        else $error("reset from powered-down detector");
    chk_illegal_no_stop: assert property (illegalOpcode |-> !stopEntered)
        else $error("stop entered while disabled");
    chk_stop_marks_busy: assert property (
        stopEntered |-> ##[0:1] stopInProgress ##1 !stopEntered)
        else $error("stop entry not followed by busy");
    chk_wdog_pulse: assert property (watchdogResetReq |=> !watchdogResetReq)
        else $error("watchdog reset not a pulse");
    chk_wdog_disabled: assert property (!watchdogEnabled |-> !watchdogResetReq)
        else $error("watchdog fired while disabled");
    chk_reset_defaults: assert property (
        $rose(rstn) |-> detectorPowerOn && watchdogEnabled && !genClocksInStop)
        else $error("outputs not at defaults after reset");
endmodule : wocfg_option_bank_assertions

//--- test/tb_write_once_option_config.sv
// Testbench: write-once option bank driven over APB
`timescale 1ns/10ps
module tb_write_once_option_config;
    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    localparam logic [11:0] A2 = wocfg_pkg::REG_TWO_ADDR;
    localparam logic [11:0] A1 = wocfg_pkg::REG_ONE_ADDR;
    logic        clk, rstn, porRstn, psel, penable, pwrite, pready, pslverr, rerr;
    logic        stopExecReq, detectorTripIn, stopWakeIn, oscInputIsClock, oscOutputIsCrystal;
    logic        slowCrystalMode, monitorXtalRange, monitorExpectLow, genClocksInStop;
    logic        detectorPowerOn, detectorActiveInStop, detectorResetReq, detectorFiveVolt;
    logic        stopEntered, illegalOpcode, stopInProgress, watchdogEnabled, watchdogResetReq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic [3:0]  pstrb;
    logic [12:0] stabCycles;
    int          num_errors, checks_done, n;
    wire logic [9:0] outs = {oscInputIsClock, oscOutputIsCrystal, slowCrystalMode,
        monitorXtalRange, monitorExpectLow, genClocksInStop, detectorPowerOn,
        detectorActiveInStop, detectorFiveVolt, watchdogEnabled};

    wocfg_option_bank DUT (.*);

    always #5 clk = ~clk;

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic finish_test;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : finish_test

    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s exp %h got %h", nm, exp, got);
        end
    endtask : chk

    // Idle cycle first, so a release is never overwritten in the same step
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        int k;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge clk);
        penable <= 1'b1;
        for (k = 0; k < 16; k++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        if (k == 16) begin
            chk("apb ready", 0, 1);
            finish_test();
        end
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 8'h00);
        chk(nm, rdat, exp);
    endtask : rd

    // Bounded wait: 0 watchdog pulse, 1 stop over, 2 detector reset
    task automatic cnt(input int w, input int lim);
        n = 0;
        while (n < lim && !((w == 0 && watchdogResetReq === 1'b1) ||
               (w == 1 && stopInProgress === 1'b0) || (w == 2 && detectorResetReq === 1'b1))) begin
            @(posedge clk);
            n++;
        end
        if (n == lim) begin
            chk("wait bound", w, 32'hffff);
            finish_test();
        end
    endtask : cnt

    task automatic stop_run(input logic trip);
        @(posedge clk);
        stopExecReq <= 1'b1;
        @(posedge clk);
        stopExecReq <= 1'b0;
        repeat (3) @(posedge clk);
        chk("in stop", stopInProgress, 1);
        stopWakeIn <= 1'b1;
        detectorTripIn <= trip;
        cnt(1, 5000);
        stopWakeIn <= 1'b0;
        detectorTripIn <= 1'b0;
    endtask : stop_run

    task automatic rst(input logic por);
        @(posedge clk);
        rstn <= 1'b0;
        porRstn <= !por;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        porRstn <= 1'b1;
    endtask : rst

    // ------------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------------
    initial begin
        {clk, rstn, porRstn, psel, penable, pwrite, stopExecReq, detectorTripIn} = '0;
        {stopWakeIn, paddr, pwdata, num_errors, checks_done} = '0;
        pstrb = 4'hf;
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        porRstn <= 1'b1;
        rd("two rst", A2, 0);
        rd("one rst", A1, 0);
        chk("outs rst", outs, 10'b0000001001);
        apb(1'b0, 12'h010, 8'h00);
        chk("unmapped err", rerr, 1);
        $display("test reset done");
        wr2(8'h07, 8'hca);
        repeat (2) @(posedge clk);
        chk("outs A", outs, 10'b1111101111);
        chk("stab A", stabCycles, 13'h1000);
        wr2(8'h08, 8'h35);
        rd("two once", A2, 8'h07);
        rd("one once", A1, 8'hca);
        rd("status", wocfg_pkg::STATUS_ADDR, 32'h7);
        apb(1'b1, wocfg_pkg::EVENT_ADDR, 8'h01);
        cnt(0, 9000);
        chk("wdog short", n >= 8168 && n <= 8180, 1);
        stop_run(1'b0);
        chk("long rec", n >= 4096 && n <= 4106, 1);
        detectorTripIn <= 1'b1;
        cnt(2, 10);
        detectorTripIn <= 1'b0;
        $display("test first setup done");
        rst(1'b0);
        rd("one sysrst", A1, 8'h08);
        wr2(8'h09, 8'h35);
        rd("one volt", A1, 8'h3d);
        repeat (2) @(posedge clk);
        chk("outs B", outs, 10'b0001010010);
        chk("stab B", stabCycles, 13'h1000);
        detectorTripIn <= 1'b1;
        stopExecReq <= 1'b1;
        repeat (6) @(posedge clk);
        chk("trip muted", detectorResetReq, 0);
        chk("illegal", illegalOpcode, 1);
        chk("no stop", stopInProgress, 0);
        detectorTripIn <= 1'b0;
        stopExecReq <= 1'b0;
        $display("test second setup done");
        rst(1'b0);
        wr2(8'h02, 8'h20);
        rd("one rstd", A1, 8'h28);
        detectorTripIn <= 1'b1;
        repeat (6) @(posedge clk);
        chk("outs D", outs, 10'b0000001011);
        chk("trip held", detectorResetReq, 0);
        detectorTripIn <= 1'b0;
        $display("test reset-disable setup done");
        rst(1'b1);
        rd("one por", A1, 0);
        pstrb <= 4'h0;
        apb(1'b1, A2, 8'h0f);
        pstrb <= 4'hf;
        wr2(8'h04, 8'h46);
        repeat (2) @(posedge clk);
        chk("outs C", outs, 10'b1000001101);
        chk("stab C", stabCycles, 13'h0010);
        stop_run(1'b0);
        chk("short rec", n >= 32 && n <= 40, 1);
        stop_run(1'b1);
        chk("trip rec", n >= 4096 && n <= 4106, 1);
        $display("test power-on setup done");
        finish_test();
    end

    task automatic wr2(input logic [7:0] two, input logic [7:0] one);
        apb(1'b1, A2, two);
        apb(1'b1, A1, one);
    endtask : wr2
endmodule : tb_write_once_option_config

bind wocfg_option_bank wocfg_option_bank_assertions #(.WDOG_W(WDOG_W), .REC_W(REC_W)) chk_i (.*);
